//--- cr_consts.svh
`ifndef CR_CONSTS_SVH
`define CR_CONSTS_SVH

// Register numbers
`define CR_REG_THERMO_MODE 16'h0200
`define CR_REG_DEFROST 16'h0201
`define CR_REG_DISPLAY 16'h0202
`define CR_REG_IN1_CFG 16'h0203
`define CR_REG_IN2_CFG 16'h0204
`define CR_REG_AUX1_CFG 16'h0205
`define CR_REG_AUX2_CFG 16'h0206
`define CR_REG_NIGHT_OFS 16'h031B
`define CR_REG_BUZZER 16'h031C
`define CR_REG_RECIRC_INT 16'h031D
`define CR_REG_RECIRC_DUR 16'h031E
`define CR_REG_OUT_STATES 16'h0500
`define CR_REG_IN_STATES 16'h0501
`define CR_REG_ALARMS 16'h0502

// Accepted write ranges
`define CR_NIGHT_MIN (-200)
`define CR_NIGHT_MAX 200
`define CR_BUZZER_MIN 0
`define CR_BUZZER_MAX 1
`define CR_RECIRC_INT_MIN 0
`define CR_RECIRC_INT_MAX 240
`define CR_RECIRC_DUR_MIN 0
`define CR_RECIRC_DUR_MAX 240

// Reset values
`define CR_NIGHT_RST 16'h0000
`define CR_BUZZER_RST 1'h0
`define CR_RECIRC_INT_RST 8'h00
`define CR_RECIRC_DUR_RST 8'h00

// Output status word bits
`define CR_OUT_COMP 0
`define CR_OUT_DEFROST 1
`define CR_OUT_FAN 2
`define CR_OUT_LIGHT 3
`define CR_OUT_DRIP 4
`define CR_OUT_STANDBY 5
`define CR_OUT_HEATER 6

// Input status word bits
`define CR_IN_DOOR 0
`define CR_IN_COMP_PROT 1
`define CR_IN_PERSON 2
`define CR_IN_PUMP_DOWN 3
`define CR_IN_REM_STANDBY 4
`define CR_IN_REM_DEF_START 5
`define CR_IN_REM_DEF_STOP 6
`define CR_IN_NIGHT 7
`define CR_IN_COUNT 8

// Alarm status word bits
`define CR_ALM_AMB_PROBE 0
`define CR_ALM_EVAP_PROBE 1
`define CR_ALM_NVM 2
`define CR_ALM_HIGH_TEMP 4
`define CR_ALM_LOW_TEMP 5
`define CR_ALM_DOOR 6
`define CR_ALM_PERSON 7
`define CR_ALM_COMP_PROT 8
`define CR_ALM_LIGHT 9

`endif

//--- cr_pkg.sv
package cr_pkg;

  typedef enum logic [1:0] {
    CR_RSP_OK,
    CR_RSP_BAD_ADDR,
    CR_RSP_BAD_VALUE
  } cr_resp_t;

  typedef struct packed {
    logic [15:0] night_ofs;
    logic buzzer;
    logic [7:0] recirc_int;
    logic [7:0] recirc_dur;
    logic [15:0] rdata;
    logic ack;
    cr_resp_t resp;
  } cr_state_t;

endpackage

//--- cr_sync.sv
`timescale 1ns/100ps
module cr_sync #(
  parameter int WIDTH = 8
) (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cr_sync_state_t;

  cr_sync_state_t cur_ff;
  cr_sync_state_t nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.meta = async_i;
    nxt_ff.stable = cur_ff.meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cur_ff <= '0;
    end else if (ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign sync_o = cur_ff.stable;

endmodule

//--- cr_range_chk.sv
`timescale 1ns/100ps
module cr_range_chk #(
  parameter int MIN_VAL = 0,
  parameter int MAX_VAL = 240
) (
  // Candidate word
  input wire logic [15:0] value_i,
  // Result
  output logic in_range_o
);

  logic signed [31:0] value_ext;

  assign value_ext = 32'(signed'(value_i));
  assign in_range_o = (value_ext >= MIN_VAL) && (value_ext <= MAX_VAL);

endmodule

//--- cr_regbank.sv
// Operation
// - Night set correction signed, -20.0 to +20.0
// - Recirculation interval minutes 0-240, zero off
// - Recirculation duration seconds, at most 240
// - Defrost method code read-only, values 0-2
// - Defrost display choice read-only, 0 or 1
// - Two input configs read-only, -8 to +8
// - Two aux relay configs read-only, -6 to +6
// - Output word: seven live relay/phase bits
// - Input word: eight digital input bits
// - Alarm low byte: seven alarm flag bits, bit 3 zero
// - Alarm high byte: compressor and light alarms
`timescale 1ns/100ps
`include "cr_consts.svh"
module cr_regbank
  import cr_pkg::*;
#(
  parameter int IN_CFG_W = 5,
  parameter int AUX_CFG_W = 4
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Register access port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output cr_resp_t resp_o,
  output logic [15:0] rdata_o,
  // Writable parameters
  output logic [15:0] night_setpoint_offset_o,
  output logic buzzer_enable_o,
  output logic [7:0] recirculation_interval_o,
  output logic [7:0] recirculation_duration_o,
  // Read-only configuration
  input wire logic thermostat_function_select_i,
  input wire logic [1:0] defrost_method_i,
  input wire logic defrost_display_choice_i,
  input wire logic [IN_CFG_W-1:0] first_input_config_i,
  input wire logic [IN_CFG_W-1:0] second_input_config_i,
  input wire logic [AUX_CFG_W-1:0] first_aux_relay_config_i,
  input wire logic [AUX_CFG_W-1:0] second_aux_relay_config_i,
  // Live output states
  input wire logic compressor_relay_i,
  input wire logic defrost_relay_i,
  input wire logic fan_relay_i,
  input wire logic room_light_relay_i,
  input wire logic dripping_phase_i,
  input wire logic standby_i,
  input wire logic heater_i,
  // Digital input pins
  input wire logic door_switch_i,
  input wire logic compressor_protect_flag_i,
  input wire logic person_in_room_i,
  input wire logic pump_down_i,
  input wire logic remote_standby_i,
  input wire logic remote_defrost_start_i,
  input wire logic remote_defrost_stop_i,
  input wire logic night_saving_i,
  // Alarm flags
  input wire logic ambient_probe_fault_i,
  input wire logic evap_probe_fault_i,
  input wire logic nvm_error_i,
  input wire logic high_temp_alarm_i,
  input wire logic low_temp_alarm_i,
  input wire logic door_open_alarm_i,
  input wire logic person_in_room_alarm_i,
  input wire logic compressor_protect_alarm_i,
  input wire logic light_alarm_i
);

  cr_state_t cur_ff;
  cr_state_t nxt_ff;
  logic [`CR_IN_COUNT-1:0] pins_raw;
  logic [`CR_IN_COUNT-1:0] pins_sync;
  logic night_ok;
  logic buzzer_ok;
  logic recirc_int_ok;
  logic recirc_dur_ok;
  logic [15:0] out_word;
  logic [15:0] in_word;
  logic [15:0] alarm_word;

  // Digital inputs come from pins
  assign pins_raw = {night_saving_i, remote_defrost_stop_i,
                     remote_defrost_start_i, remote_standby_i,
                     pump_down_i, person_in_room_i,
                     compressor_protect_flag_i, door_switch_i};

  cr_sync #(
    .WIDTH(`CR_IN_COUNT)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  // Write value checks
  cr_range_chk #(
    .MIN_VAL(`CR_NIGHT_MIN),
    .MAX_VAL(`CR_NIGHT_MAX)
  ) u_night_chk (
    .value_i(wdata_i),
    .in_range_o(night_ok)
  );

  cr_range_chk #(
    .MIN_VAL(`CR_BUZZER_MIN),
    .MAX_VAL(`CR_BUZZER_MAX)
  ) u_buzzer_chk (
    .value_i(wdata_i),
    .in_range_o(buzzer_ok)
  );

  cr_range_chk #(
    .MIN_VAL(`CR_RECIRC_INT_MIN),
    .MAX_VAL(`CR_RECIRC_INT_MAX)
  ) u_int_chk (
    .value_i(wdata_i),
    .in_range_o(recirc_int_ok)
  );

  cr_range_chk #(
    .MIN_VAL(`CR_RECIRC_DUR_MIN),
    .MAX_VAL(`CR_RECIRC_DUR_MAX)
  ) u_dur_chk (
    .value_i(wdata_i),
    .in_range_o(recirc_dur_ok)
  );

  // Status word assembly, unused bits zero
  always_comb begin
    out_word = 16'h0000;
    out_word[`CR_OUT_COMP] = compressor_relay_i;
    out_word[`CR_OUT_DEFROST] = defrost_relay_i;
    out_word[`CR_OUT_FAN] = fan_relay_i;
    out_word[`CR_OUT_LIGHT] = room_light_relay_i;
    out_word[`CR_OUT_DRIP] = dripping_phase_i;
    out_word[`CR_OUT_STANDBY] = standby_i;
    out_word[`CR_OUT_HEATER] = heater_i;
    in_word = {8'h00, pins_sync};
    alarm_word = 16'h0000;
    alarm_word[`CR_ALM_AMB_PROBE] = ambient_probe_fault_i;
    alarm_word[`CR_ALM_EVAP_PROBE] = evap_probe_fault_i;
    alarm_word[`CR_ALM_NVM] = nvm_error_i;
    alarm_word[`CR_ALM_HIGH_TEMP] = high_temp_alarm_i;
    alarm_word[`CR_ALM_LOW_TEMP] = low_temp_alarm_i;
    alarm_word[`CR_ALM_DOOR] = door_open_alarm_i;
    alarm_word[`CR_ALM_PERSON] = person_in_room_alarm_i;
    alarm_word[`CR_ALM_COMP_PROT] = compressor_protect_alarm_i;
    alarm_word[`CR_ALM_LIGHT] = light_alarm_i;
  end

  // Access handling
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'h0;
    if (req_i) begin
      nxt_ff.ack = 1'h1;
      nxt_ff.resp = CR_RSP_OK;
      nxt_ff.rdata = 16'h0000;
      if (!we_i) begin
        if (addr_i == `CR_REG_THERMO_MODE) begin
          nxt_ff.rdata = {15'h0000, thermostat_function_select_i};
        end else if (addr_i == `CR_REG_DEFROST) begin
          nxt_ff.rdata = {14'h0000, defrost_method_i};
        end else if (addr_i == `CR_REG_DISPLAY) begin
          nxt_ff.rdata = {15'h0000, defrost_display_choice_i};
        end else if (addr_i == `CR_REG_IN1_CFG) begin
          nxt_ff.rdata = 16'(signed'(first_input_config_i));
        end else if (addr_i == `CR_REG_IN2_CFG) begin
          nxt_ff.rdata = 16'(signed'(second_input_config_i));
        end else if (addr_i == `CR_REG_AUX1_CFG) begin
          nxt_ff.rdata = 16'(signed'(first_aux_relay_config_i));
        end else if (addr_i == `CR_REG_AUX2_CFG) begin
          nxt_ff.rdata = 16'(signed'(second_aux_relay_config_i));
        end else if (addr_i == `CR_REG_NIGHT_OFS) begin
          nxt_ff.rdata = cur_ff.night_ofs;
        end else if (addr_i == `CR_REG_BUZZER) begin
          nxt_ff.rdata = {15'h0000, cur_ff.buzzer};
        end else if (addr_i == `CR_REG_RECIRC_INT) begin
          nxt_ff.rdata = {8'h00, cur_ff.recirc_int};
        end else if (addr_i == `CR_REG_RECIRC_DUR) begin
          nxt_ff.rdata = {8'h00, cur_ff.recirc_dur};
        end else if (addr_i == `CR_REG_OUT_STATES) begin
          nxt_ff.rdata = out_word;
        end else if (addr_i == `CR_REG_IN_STATES) begin
          nxt_ff.rdata = in_word;
        end else if (addr_i == `CR_REG_ALARMS) begin
          nxt_ff.rdata = alarm_word;
        end else begin
          nxt_ff.resp = CR_RSP_BAD_ADDR;
        end
      end else begin
        nxt_ff.rdata = wdata_i;
        if (addr_i == `CR_REG_NIGHT_OFS) begin
          if (night_ok) begin
            nxt_ff.night_ofs = wdata_i;
          end else begin
            nxt_ff.resp = CR_RSP_BAD_VALUE;
          end
        end else if (addr_i == `CR_REG_BUZZER) begin
          if (buzzer_ok) begin
            nxt_ff.buzzer = wdata_i[0];
          end else begin
            nxt_ff.resp = CR_RSP_BAD_VALUE;
          end
        end else if (addr_i == `CR_REG_RECIRC_INT) begin
          if (recirc_int_ok) begin
            nxt_ff.recirc_int = wdata_i[7:0];
          end else begin
            nxt_ff.resp = CR_RSP_BAD_VALUE;
          end
        end else if (addr_i == `CR_REG_RECIRC_DUR) begin
          if (recirc_dur_ok) begin
            nxt_ff.recirc_dur = wdata_i[7:0];
          end else begin
            nxt_ff.resp = CR_RSP_BAD_VALUE;
          end
        end else if ((addr_i >= `CR_REG_THERMO_MODE &&
                      addr_i <= `CR_REG_AUX2_CFG) ||
                     (addr_i >= `CR_REG_OUT_STATES &&
                      addr_i <= `CR_REG_ALARMS)) begin
          nxt_ff.resp = CR_RSP_OK;
        end else begin
          nxt_ff.resp = CR_RSP_BAD_ADDR;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cur_ff.night_ofs <= `CR_NIGHT_RST;
      cur_ff.buzzer <= `CR_BUZZER_RST;
      cur_ff.recirc_int <= `CR_RECIRC_INT_RST;
      cur_ff.recirc_dur <= `CR_RECIRC_DUR_RST;
      cur_ff.rdata <= 16'h0000;
      cur_ff.ack <= 1'h0;
      cur_ff.resp <= CR_RSP_OK;
    end else if (ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign ack_o = cur_ff.ack;
  assign resp_o = cur_ff.resp;
  assign rdata_o = cur_ff.rdata;
  assign night_setpoint_offset_o = cur_ff.night_ofs;
  assign buzzer_enable_o = cur_ff.buzzer;
  assign recirculation_interval_o = cur_ff.recirc_int;
  assign recirculation_duration_o = cur_ff.recirc_dur;

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_rd(logic [15:0] a);
    ce_i && req_i && !we_i && addr_i == a;
  endsequence

  sequence s_wr(logic [15:0] a);
    ce_i && req_i && we_i && addr_i == a;
  endsequence

  a_night_range: assert property (
    $signed(night_setpoint_offset_o) >= -16'sd200 &&
    $signed(night_setpoint_offset_o) <= 16'sd200)
    else $error("night offset out of range");

  a_night_reject: assert property (
    s_wr(`CR_REG_NIGHT_OFS) ##0 !night_ok |=>
    $stable(night_setpoint_offset_o) && resp_o == CR_RSP_BAD_VALUE)
    else $error("bad night offset was stored");

  a_interval_write: assert property (
    s_wr(`CR_REG_RECIRC_INT) ##0 (wdata_i <= 16'h00F0) |=>
    recirculation_interval_o == $past(wdata_i[7:0]) && ack_o)
    else $error("interval write not stored");

  a_duration_cap: assert property (
    recirculation_duration_o <= 8'hF0)
    else $error("duration above limit");

  a_defrost_read: assert property (
    s_rd(`CR_REG_DEFROST) |=>
    rdata_o == {14'h0000, $past(defrost_method_i)} && ack_o)
    else $error("defrost method read wrong");

  a_display_read: assert property (
    s_rd(`CR_REG_DISPLAY) |=> rdata_o[15:1] == 15'h0000 &&
    rdata_o[0] == $past(defrost_display_choice_i))
    else $error("display choice read wrong");

  a_input_cfg_read: assert property (
    s_rd(`CR_REG_IN2_CFG) |=>
    $signed(rdata_o) == $signed($past(second_input_config_i)))
    else $error("input config not sign extended");

  a_aux_cfg_read: assert property (
    s_rd(`CR_REG_AUX1_CFG) |=>
    $signed(rdata_o) == $signed($past(first_aux_relay_config_i)))
    else $error("aux config not sign extended");

  a_out_word: assert property (
    s_rd(`CR_REG_OUT_STATES) |=> rdata_o[15:7] == 9'h000 &&
    rdata_o[0] == $past(compressor_relay_i) &&
    rdata_o[6] == $past(heater_i))
    else $error("output status word wrong");

  a_in_word: assert property (
    s_rd(`CR_REG_IN_STATES) |=> rdata_o[15:8] == 8'h00 &&
    rdata_o[7] == $past(pins_sync[`CR_IN_NIGHT]))
    else $error("input status word wrong");

  a_alarm_low: assert property (
    s_rd(`CR_REG_ALARMS) |=> rdata_o[3] == 1'h0 &&
    rdata_o[7] == $past(person_in_room_alarm_i))
    else $error("alarm low byte wrong");

  a_alarm_high: assert property (
    s_rd(`CR_REG_ALARMS) |=> rdata_o[15:10] == 6'h00 &&
    rdata_o[9] == $past(light_alarm_i) &&
    rdata_o[8] == $past(compressor_protect_alarm_i))
    else $error("alarm high byte wrong");

  a_ro_ignored: assert property (
    s_wr(`CR_REG_DEFROST) |=> $stable(night_setpoint_offset_o) &&
    $stable(buzzer_enable_o) && resp_o == CR_RSP_OK)
    else $error("read-only write had effect");

  a_buzzer_set: assert property (
    s_wr(`CR_REG_BUZZER) ##0 (wdata_i == 16'h0001) |=>
    buzzer_enable_o && ack_o && resp_o == CR_RSP_OK)
    else $error("buzzer enable not set");

endmodule

//--- cr_master_model.sv
`timescale 1ns/100ps
module cr_master_model
  import cr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Operation from the bench
  input wire logic start_i,
  input wire logic op_we_i,
  input wire logic [15:0] op_addr_i,
  input wire logic [15:0] op_wdata_i,
  output logic done_o,
  output logic [15:0] got_rdata_o,
  output cr_resp_t got_resp_o,
  // Register access port
  output logic req_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic ack_i,
  input wire cr_resp_t resp_i,
  input wire logic [15:0] rdata_i
);
  logic busy;
  // One-cycle request pulse, then wait for the answer
  always @(posedge core_clk_i) begin
    done_o <= 1'b0;
    req_o <= 1'b0;
    if (srst_i) begin
      busy <= 1'b0;
      we_o <= 1'b0;
      addr_o <= 16'h0000;
      wdata_o <= 16'h0000;
    end else if (start_i && !busy) begin
      busy <= 1'b1;
      req_o <= 1'b1;
      we_o <= op_we_i;
      addr_o <= op_addr_i;
      wdata_o <= op_wdata_i;
    end else begin
      // Released address and data lines do not keep their last value
      if (!req_o) begin
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
      end
      if (busy && ack_i) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        got_rdata_o <= rdata_i;
        got_resp_o <= resp_i;
      end
    end
  end
endmodule

//--- cold_room_controller_register_map_tb_top.sv
`timescale 1ns/100ps
module cold_room_controller_register_map_tb_top;
  import cr_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic op_we = 1'b0;
  logic [15:0] op_addr = 16'h0000;
  logic [15:0] op_wdata = 16'h0000;
  logic done, req, we, ack, buz;
  logic [15:0] got_rd, addr, wdata, rdata, night;
  cr_resp_t got_rs, resp;
  logic [7:0] rint, rdur;
  logic thermo = 1'b0;
  logic [1:0] dmeth = 2'h0;
  logic disp = 1'b0;
  logic [4:0] in1 = 5'h00;
  logic [4:0] in2 = 5'h00;
  logic [3:0] aux1 = 4'h0;
  logic [3:0] aux2 = 4'h0;
  logic [6:0] outs = 7'h00;
  logic [7:0] pins = 8'h00;
  logic [8:0] alms = 9'h000;
  int error_cnt = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  cr_master_model u_cr_master_model (.core_clk_i(core_clk), .srst_i(srst),
    .start_i(start), .op_we_i(op_we), .op_addr_i(op_addr),
    .op_wdata_i(op_wdata), .done_o(done), .got_rdata_o(got_rd),
    .got_resp_o(got_rs), .req_o(req), .we_o(we), .addr_o(addr),
    .wdata_o(wdata), .ack_i(ack), .resp_i(resp), .rdata_i(rdata));
  cr_regbank u_cr_regbank (.core_clk_i(core_clk), .srst_i(srst), .ce_i(ce),
    .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
    .resp_o(resp), .rdata_o(rdata), .night_setpoint_offset_o(night),
    .buzzer_enable_o(buz), .recirculation_interval_o(rint),
    .recirculation_duration_o(rdur), .thermostat_function_select_i(thermo),
    .defrost_method_i(dmeth), .defrost_display_choice_i(disp),
    .first_input_config_i(in1), .second_input_config_i(in2),
    .first_aux_relay_config_i(aux1), .second_aux_relay_config_i(aux2),
    .compressor_relay_i(outs[0]), .defrost_relay_i(outs[1]),
    .fan_relay_i(outs[2]), .room_light_relay_i(outs[3]),
    .dripping_phase_i(outs[4]), .standby_i(outs[5]), .heater_i(outs[6]),
    .door_switch_i(pins[0]), .compressor_protect_flag_i(pins[1]),
    .person_in_room_i(pins[2]), .pump_down_i(pins[3]),
    .remote_standby_i(pins[4]), .remote_defrost_start_i(pins[5]),
    .remote_defrost_stop_i(pins[6]), .night_saving_i(pins[7]),
    .ambient_probe_fault_i(alms[0]), .evap_probe_fault_i(alms[1]),
    .nvm_error_i(alms[2]), .high_temp_alarm_i(alms[3]),
    .low_temp_alarm_i(alms[4]), .door_open_alarm_i(alms[5]),
    .person_in_room_alarm_i(alms[6]), .compressor_protect_alarm_i(alms[7]),
    .light_alarm_i(alms[8]));
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One access through the master model, bounded wait for its answer
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] rd, output logic [15:0] rs);
    int n;
    @(posedge core_clk);
    start <= 1'b1;
    op_we <= w;
    op_addr <= a;
    op_wdata <= d;
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      error_cnt++;
      $display("unexpected answer: expected done, seen timeout");
      tally_and_finish();
    end
    rd = got_rd;
    rs = {14'h0000, got_rs};
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [15:0] exp);
    logic [15:0] r, s;
    acc(1'b0, a, 16'h0000, r, s);
    chk(nm, exp, r);
    chk("read resp", {14'h0000, CR_RSP_OK}, s);
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_rw;
    logic [15:0] ad [11];
    logic [15:0] wd [11];
    cr_resp_t rp [11];
    logic [15:0] kp [11];
    logic [15:0] r, s, port;
    ad = '{16'h031B, 16'h031B, 16'h031B, 16'h031B, 16'h031D, 16'h031D,
           16'h031E, 16'h031E, 16'h031C, 16'h031C, 16'h031C};
    wd = '{16'hFF38, 16'h00C9, 16'h00C8, 16'hFF37, 16'h00F0, 16'h00F1,
           16'h00F0, 16'h00F1, 16'h0001, 16'h0002, 16'h0000};
    rp = '{CR_RSP_OK, CR_RSP_BAD_VALUE, CR_RSP_OK, CR_RSP_BAD_VALUE,
           CR_RSP_OK, CR_RSP_BAD_VALUE, CR_RSP_OK, CR_RSP_BAD_VALUE,
           CR_RSP_OK, CR_RSP_BAD_VALUE, CR_RSP_OK};
    kp = '{16'hFF38, 16'hFF38, 16'h00C8, 16'h00C8, 16'h00F0, 16'h00F0,
           16'h00F0, 16'h00F0, 16'h0001, 16'h0001, 16'h0000};
    for (int i = 0; i < 11; i++) begin
      acc(1'b1, ad[i], wd[i], r, s);
      chk("write resp", {14'h0000, rp[i]}, s);
      case (ad[i])
        16'h031B: port = night;
        16'h031C: port = {15'h0000, buz};
        16'h031D: port = {8'h00, rint};
        default: port = {8'h00, rdur};
      endcase
      chk("parameter port", kp[i], port);
      rd_chk("parameter read", ad[i], kp[i]);
    end
    $display("test writable parameters done");
  endtask
  task automatic t_ro;
    logic [15:0] r, s;
    for (int k = 0; k < 3; k++) begin
      dmeth <= 2'(k);
      rd_chk("defrost method", 16'h0201, 16'(k));
    end
    for (int k = 0; k < 2; k++) begin
      disp <= 1'(k);
      rd_chk("display choice", 16'h0202, 16'(k));
    end
    for (int k = 0; k < 2; k++) begin
      thermo <= 1'(k);
      rd_chk("thermostat mode", 16'h0200, 16'(k));
    end
    in1 <= 5'h18;
    in2 <= 5'h08;
    aux1 <= 4'hA;
    aux2 <= 4'h6;
    rd_chk("input cfg 1", 16'h0203, 16'hFFF8);
    rd_chk("input cfg 2", 16'h0204, 16'h0008);
    rd_chk("aux cfg 1", 16'h0205, 16'hFFFA);
    rd_chk("aux cfg 2", 16'h0206, 16'h0006);
    acc(1'b1, 16'h0201, 16'h0000, r, s);
    chk("ro write resp", {14'h0000, CR_RSP_OK}, s);
    chk("ro write kept night", 16'h00C8, night);
    rd_chk("defrost kept", 16'h0201, 16'h0002);
    $display("test read-only config done");
  endtask
  task automatic t_status;
    int apos [9];
    apos = '{0, 1, 2, 4, 5, 6, 7, 8, 9};
    for (int i = 0; i < 7; i++) begin
      outs <= 7'h01 << i;
      settle();
      rd_chk("output word", 16'h0500, 16'h0001 << i);
    end
    for (int i = 0; i < 8; i++) begin
      pins <= 8'h01 << i;
      settle();
      rd_chk("input word", 16'h0501, 16'h0001 << i);
    end
    for (int i = 0; i < 9; i++) begin
      alms <= 9'h001 << i;
      settle();
      rd_chk("alarm word", 16'h0502, 16'h0001 << apos[i]);
    end
    outs <= 7'h7F;
    pins <= 8'hFF;
    alms <= 9'h1FF;
    settle();
    rd_chk("output word full", 16'h0500, 16'h007F);
    rd_chk("input word full", 16'h0501, 16'h00FF);
    rd_chk("alarm word full", 16'h0502, 16'h03F7);
    $display("test status words done");
  endtask
  task automatic t_refuse;
    logic [15:0] r, s;
    acc(1'b1, 16'h0207, 16'h0005, r, s);
    chk("unmapped resp", {14'h0000, CR_RSP_BAD_ADDR}, s);
    acc(1'b1, 16'h031F, 16'h0005, r, s);
    chk("unmapped resp", {14'h0000, CR_RSP_BAD_ADDR}, s);
    acc(1'b0, 16'h0503, 16'h0000, r, s);
    chk("unmapped read resp", {14'h0000, CR_RSP_BAD_ADDR}, s);
    rd_chk("duration kept", 16'h031E, 16'h00F0);
    $display("test unmapped addresses done");
  endtask
  // Enable drops right after the request is taken, so the answer must hold
  task automatic t_freeze;
    @(posedge core_clk);
    start <= 1'b1;
    op_we <= 1'b0;
    op_addr <= 16'h0500;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk("ack held while frozen", 16'h0001, {15'h0000, ack});
    chk("read held while frozen", 16'h007F, rdata);
    @(posedge core_clk);
    ce <= 1'b1;
    @(negedge core_clk);
    chk("ack still held", 16'h0001, {15'h0000, ack});
    @(negedge core_clk);
    chk("ack after thaw", 16'h0000, {15'h0000, ack});
    $display("test clock enable freeze done");
  endtask
  // Reset in mid-run clears every written parameter
  task automatic t_rst_mid;
    logic [15:0] r, s;
    acc(1'b1, 16'h031C, 16'h0001, r, s);
    chk("buzzer before reset", 16'h0001, {15'h0000, buz});
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk("night after reset", 16'h0000, night);
    chk("buzzer after reset", 16'h0000, {15'h0000, buz});
    chk("interval after reset", 16'h0000, {8'h00, rint});
    chk("duration after reset", 16'h0000, {8'h00, rdur});
    chk("ack after reset", 16'h0000, {15'h0000, ack});
    rd_chk("duration reset read", 16'h031E, 16'h0000);
    rd_chk("night reset read", 16'h031B, 16'h0000);
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("night reset", 16'h031B, 16'h0000);
    rd_chk("buzzer reset", 16'h031C, 16'h0000);
    $display("test reset values done");
    t_rw();
    t_ro();
    t_status();
    t_refuse();
    t_freeze();
    t_rst_mid();
    tally_and_finish();
  end
endmodule
